// ===== hdl/smc_core.sv
// Resident monitor command core: sorts host bytes into commands and data,
// keeps shift data, memory pointer, state flags and saved user context.
// Assumes received bytes are presented as a one-cycle strobe, the memory
// answers a read request one cycle later, and the link drains the TX FIFO.
// How it works
// - bytes below 32 are commands, others data
// - literal flag makes next byte data, then clears
// - data byte shifts data left, fills low byte
// - transmit sends low byte, shifts right, bumps pointer
// - only transmit ever sends a byte
// - command 00 sets the literal flag
// - command 04 loads memory byte into low byte
// - 16-bit pointer addresses every memory access
// - 8-bit state flags: literal, run, trap, diag
// - trap set on halt trap, cleared on start
// - run flag high while user code executes
// - saved_program_counter and PSW saved while stopped
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO, valid/ready on both sides
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : smc_fifo

// One state flag with set and clear pulses; priority chosen per flag
module smc_flag_cell #(
  parameter bit SET_WINS = 1'b1,
  parameter bit RESET_VAL = 1'b0
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic set_in, // Set pulse
  input wire logic clr_in, // Clear pulse
  output logic flag_q // Flag value
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RESET_VAL;
    end else if (set_in && (SET_WINS || !clr_in)) begin
      flag_q <= 1'b1;
    end else if (clr_in) begin
      flag_q <= 1'b0;
    end
  end
endmodule : smc_flag_cell

// Output copy so every top-level port comes straight from a flop
module smc_hold_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic [WIDTH-1:0] d, // Internal value
  output logic [WIDTH-1:0] q // Registered copy
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end
endmodule : smc_hold_reg

module smc_core
  import smc_pkg::*;
(
  input wire logic CLOCK, // System clock, 100 MHz
  input wire logic RSTN, // Async reset, active low
  input wire logic RX_VALID, // Received byte strobe
  input wire logic [7:0] RX_DATA, // Received byte
  output logic RX_READY, // Core can take a byte
  output logic TX_VALID, // Byte for host available
  input wire logic TX_READY, // Link takes the byte
  output logic [7:0] TX_DATA, // Byte for host
  output var smc_pkg::smc_mem_req_t MEM_REQ, // Memory read request
  input wire logic [7:0] MEM_RDATA, // Read data, one cycle later
  input wire logic USER_START, // Pulse: user code starts
  input wire logic USER_STOP, // Pulse: user code stops
  input wire logic USER_TRAP, // Pulse: user code halts on trap
  input wire logic DIAG_MODE, // Diagnostic mode select
  input wire smc_pkg::smc_user_ctx_t USER_CTX, // Live saved_program_counter and PSW
  output logic [31:0] SHIFT_DATA, // Shift data register
  output logic [15:0] MEM_POINTER, // Memory pointer
  output logic [7:0] STATE_FLAGS, // State flags register
  output var smc_pkg::smc_user_ctx_t SAVED_CTX // Saved user context
);
  import smc_pkg::*;

  smc_state_t state_q;
  logic [31:0] data_q;
  logic [15:0] addr_q;
  logic [7:0] flag_bits;
  logic lit_q, run_q, trap_q, diag_q;
  smc_user_ctx_t ctx_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic take, is_cmd, is_data;
  logic cmd_lit, cmd_tx, cmd_rd;
  logic tx_push;

  // Stall intake while a read is in flight, for a cycle after a transmit, or while the send queue is full
  assign take = RX_VALID && RX_READY;
  assign is_cmd = take && (RX_DATA < CMD_LIMIT) &&
    !lit_q;
  assign is_data = take && !is_cmd;
  assign cmd_lit = is_cmd && (RX_DATA == CMD_FORCE_LITERAL);
  assign cmd_tx = is_cmd && (RX_DATA == CMD_TRANSMIT);
  assign cmd_rd = is_cmd && (RX_DATA == CMD_READ_BYTE);
  // Any other code falls through with nothing changed
  assign tx_push = cmd_tx;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_rd) begin
            state_q <= ST_READ;
          end
        end
        // Request cycle, then one cycle for the memory to answer
        ST_READ: begin
          state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RX_READY <= 1'b0;
    end else begin
      // Full FIFO refuses transmits, so hold all bytes to keep order
      RX_READY <= (state_q == ST_IDLE) && !cmd_rd && !tx_push &&
        fifo_in_ready;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      data_q <= DATA_RESET;
    end else if (is_data) begin
      data_q <= {data_q[23:0], RX_DATA};
    end else if (cmd_tx) begin
      data_q <= {8'h00, data_q[31:8]};
    end else if (state_q == ST_LOAD) begin
      data_q <= {data_q[31:8], MEM_RDATA};
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      addr_q <= ADDR_RESET;
    end else if (cmd_tx) begin
      addr_q <= addr_q + 16'h0001;
    end
  end

  // Request leaves on a flop; its answer is loaded two edges later
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_REQ <= '0;
    end else begin
      MEM_REQ.valid <= cmd_rd;
      MEM_REQ.addr <= addr_q;
    end
  end

  // Command and data byte never coincide, so priority is moot here
  smc_flag_cell #(
    .SET_WINS(1'b1),
    .RESET_VAL(FLAGS_RESET[FLAG_LITERAL])
  ) u_lit_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .set_in(cmd_lit),
    .clr_in(is_data),
    .flag_q(lit_q)
  );

  // Stop or trap wins over start if both arrive together
  smc_flag_cell #(
    .SET_WINS(1'b0),
    .RESET_VAL(FLAGS_RESET[FLAG_RUN])
  ) u_run_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .set_in(USER_START),
    .clr_in(USER_STOP || USER_TRAP),
    .flag_q(run_q)
  );

  smc_flag_cell #(
    .SET_WINS(1'b1),
    .RESET_VAL(FLAGS_RESET[FLAG_TRAP])
  ) u_trap_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .set_in(USER_TRAP),
    .clr_in(USER_START),
    .flag_q(trap_q)
  );

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      diag_q <= FLAGS_RESET[FLAG_DIAG];
    end else begin
      diag_q <= DIAG_MODE;
    end
  end

  // Spare bits stay at their reset value
  always_comb begin
    flag_bits = FLAGS_RESET;
    flag_bits[FLAG_LITERAL] = lit_q;
    flag_bits[FLAG_RUN] = run_q;
    flag_bits[FLAG_TRAP] = trap_q;
    flag_bits[FLAG_DIAG] = diag_q;
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctx_q <= {SAVE_PC_RESET, SAVE_PSW_RESET};
    end else if ((USER_STOP || USER_TRAP) && run_q) begin
      ctx_q <= USER_CTX;
    end
  end

  smc_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLOCK),
    .rst_n(RSTN),
    .in_valid(tx_push),
    .in_ready(fifo_in_ready),
    .in_data(data_q[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(TX_READY && !TX_VALID),
    .out_data(fifo_out_data)
  );

  // Output stage register so the link sees flop-driven signals
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
    end else if (TX_VALID) begin
      if (TX_READY) begin
        TX_VALID <= 1'b0;
      end
    end else if (fifo_out_valid && TX_READY) begin
      TX_VALID <= 1'b1;
      TX_DATA <= fifo_out_data;
    end
  end

  smc_hold_reg #(
    .WIDTH(DATA_W),
    .RESET_VAL(DATA_RESET)
  ) u_shift_out (
    .clk(CLOCK),
    .rst_n(RSTN),
    .d(data_q),
    .q(SHIFT_DATA)
  );

  smc_hold_reg #(
    .WIDTH(ADDR_W),
    .RESET_VAL(ADDR_RESET)
  ) u_pointer_out (
    .clk(CLOCK),
    .rst_n(RSTN),
    .d(addr_q),
    .q(MEM_POINTER)
  );

  smc_hold_reg #(
    .WIDTH($bits(flag_bits)),
    .RESET_VAL(FLAGS_RESET)
  ) u_flags_out (
    .clk(CLOCK),
    .rst_n(RSTN),
    .d(flag_bits),
    .q(STATE_FLAGS)
  );

  smc_hold_reg #(
    .WIDTH($bits(smc_user_ctx_t)),
    .RESET_VAL({SAVE_PC_RESET, SAVE_PSW_RESET})
  ) u_ctx_out (
    .clk(CLOCK),
    .rst_n(RSTN),
    .d(ctx_q),
    .q(SAVED_CTX)
  );
endmodule : smc_core
`default_nettype wire

// ===== hdl/smc_fifo.sv
// Intentionally empty: the transmit FIFO module is defined beside the core.
// All logic of the block sits in one design file with its helper cells.

// ===== hdl/smc_pkg.sv
// Package for the serial monitor command core: codes, field layouts, widths.
// Assumes one clock domain; byte stream arrives already deserialised.
package smc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] CMD_LIMIT = 8'h20;
  localparam logic [7:0] CMD_FORCE_LITERAL = 8'h00;
  localparam logic [7:0] CMD_TRANSMIT = 8'h02;
  localparam logic [7:0] CMD_READ_BYTE = 8'h04;
  localparam int FLAG_LITERAL = 0;
  localparam int FLAG_RUN = 1;
  localparam int FLAG_TRAP = 2;
  localparam int FLAG_DIAG = 3;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SAVE_PC_RESET = 16'h0000;
  localparam logic [15:0] SAVE_PSW_RESET = 16'h0000;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] psw;
  } smc_user_ctx_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } smc_mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_LOAD = 3'b100
  } smc_state_t;
endpackage : smc_pkg

// ===== tb/smc_host_model.sv
// Host side of the link: takes reply bytes.
// Assumes replies arrive as valid/ready.
`timescale 1ns/1ps
`default_nettype none
module smc_host_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic tx_valid, // Reply
  input wire logic [7:0] tx_data, // Byte
  output logic tx_ready, // Accept
  output logic [7:0] last_q, // Last byte
  output int count_q // Bytes seen
);
  // Prompt host only; stalls are not modelled
  assign tx_ready = 1'b1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 8'h00;
      count_q <= 0;
    end else if (tx_valid && tx_ready) begin
      last_q <= tx_data;
      count_q <= count_q + 1;
    end
  end
endmodule : smc_host_model
`default_nettype wire

// ===== tb/smc_monitor.sv
// Checker on the core's ports.
// Assumes the host keeps TX_READY high.
`timescale 1ns/1ps
`default_nettype none
module smc_monitor
  import smc_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic RSTN, // Reset
  input wire logic RX_VALID, // Offer
  input wire logic [7:0] RX_DATA, // Byte
  input wire logic RX_READY, // Take
  input wire logic TX_VALID, // Reply
  input wire smc_pkg::smc_mem_req_t MEM_REQ, // Read
  input wire logic [15:0] MEM_POINTER, // Pointer
  input wire logic [31:0] SHIFT_DATA, // Data
  input wire logic [7:0] STATE_FLAGS // Flags
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  wire logic take = RX_VALID && RX_READY;
  // Tracks an escape so a following low byte is not read as a command
  logic lit_q;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lit_q <= 1'b0;
    end else if (take) begin
      lit_q <= !lit_q && (RX_DATA == CMD_FORCE_LITERAL);
    end
  end
  a_data_low:
    assert property (take && (RX_DATA >= CMD_LIMIT || lit_q) |->
      ##2 SHIFT_DATA[7:0] == $past(RX_DATA, 2)) else $error("data lost");
  a_tx_cause:
    assert property ($rose(TX_VALID) |-> $past(take, 2) &&
      !$past(lit_q, 2) && $past(RX_DATA, 2) == CMD_TRANSMIT)
      else $error("tx");
  a_tx_stall:
    assert property (take && !lit_q && RX_DATA == CMD_TRANSMIT |=>
      !RX_READY) else $error("tx stall");
  a_read_stall:
    assert property (take && !lit_q && RX_DATA == CMD_READ_BYTE |=>
      !RX_READY [*3]) else $error("read stall");
  a_req_cause:
    assert property ($rose(MEM_REQ.valid) |-> $past(take) &&
      !$past(lit_q) && $past(RX_DATA) == CMD_READ_BYTE) else $error("req");
  a_req_addr:
    assert property (MEM_REQ.valid |-> MEM_REQ.addr == MEM_POINTER
      ##1 !MEM_REQ.valid) else $error("req addr");
  a_ptr_step:
    assert property ($changed(MEM_POINTER) |->
      MEM_POINTER == $past(MEM_POINTER) + 16'h1) else $error("pointer");
  a_flag_spare:
    assert property (STATE_FLAGS[7:4] == 4'h0) else $error("spare flags");
endmodule : smc_monitor
bind smc_core smc_monitor i_mon (.CLOCK, .RSTN, .RX_VALID, .RX_DATA,
  .RX_READY, .TX_VALID, .MEM_REQ, .MEM_POINTER, .SHIFT_DATA, .STATE_FLAGS);
`default_nettype wire

// ===== tb/tb_serial_monitor_command_core.sv
// Bench: host bytes in, replies, memory reads, user flags.
// Assumes memory answers a read request in the following cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_monitor_command_core;
  import smc_pkg::*;
  logic CLOCK = 1'b0, RSTN = 1'b0, RX_VALID = 1'b0, DIAG_MODE = 1'b0;
  logic USER_START = 1'b0, USER_STOP = 1'b0, USER_TRAP = 1'b0;
  logic [7:0] RX_DATA = 8'h00, MEM_RDATA, TX_DATA, STATE_FLAGS, last;
  logic RX_READY, TX_VALID, TX_READY;
  smc_user_ctx_t USER_CTX = '0, SAVED_CTX;
  smc_mem_req_t MEM_REQ;
  logic [31:0] SHIFT_DATA;
  logic [15:0] MEM_POINTER;
  int num_errors = 0, checked = 0, count;
  always #5 CLOCK = ~CLOCK;
  // Registered memory: data follows the request by one cycle
  always @(posedge CLOCK) begin
    if (MEM_REQ.valid) begin
      MEM_RDATA <= MEM_REQ.addr[7:0] ^ 8'hA5;
    end
  end
  smc_core i_dut (.CLOCK, .RSTN, .RX_VALID, .RX_DATA, .RX_READY, .TX_VALID,
    .TX_READY, .TX_DATA, .MEM_REQ, .MEM_RDATA, .USER_START, .USER_STOP,
    .USER_TRAP, .DIAG_MODE, .USER_CTX, .SHIFT_DATA, .MEM_POINTER,
    .STATE_FLAGS, .SAVED_CTX);
  smc_host_model i_host (.clk(CLOCK), .rst_n(RSTN), .tx_valid(TX_VALID),
    .tx_data(TX_DATA), .tx_ready(TX_READY), .last_q(last), .count_q(count));
  task chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task send(input logic [7:0] b);
    RX_VALID <= 1'b1;
    RX_DATA <= b;
    do @(posedge CLOCK); while (RX_READY !== 1'b1);
    RX_VALID <= 1'b0;
    RX_DATA <= ~b; // Idle line must not look like the last byte
    repeat (4) @(posedge CLOCK);
  endtask : send
  task user(input logic [2:0] p);
    {USER_TRAP, USER_STOP, USER_START} <= p;
    @(posedge CLOCK);
    {USER_TRAP, USER_STOP, USER_START} <= 3'b000;
    repeat (3) @(posedge CLOCK);
  endtask : user
  task t_data;
    send(8'h41);
    send(8'h42);
    send(8'h43);
    send(8'h44);
    send(8'h45);
    chk("data", SHIFT_DATA, 32'h42434445);
    send(8'h01);
    send(8'h1F);
    chk("unknown", SHIFT_DATA, 32'h42434445);
    send(CMD_FORCE_LITERAL);
    chk("lit set", STATE_FLAGS[FLAG_LITERAL], 1'b1);
    send(8'h05);
    chk("escaped", SHIFT_DATA, 32'h43444505);
    chk("lit clr", STATE_FLAGS[FLAG_LITERAL], 1'b0);
    chk("silent", count, 0);
    $display("t_data done");
  endtask : t_data
  task t_tx;
    send(CMD_TRANSMIT);
    chk("tx1", last, 8'h05);
    send(CMD_TRANSMIT);
    chk("tx2", last, 8'h45);
    chk("shifted", SHIFT_DATA, 32'h00004344);
    chk("pointer", MEM_POINTER, 16'h0002);
    send(CMD_READ_BYTE);
    chk("read", SHIFT_DATA, 32'h000043A7);
    chk("replies", count, 2);
    $display("t_tx done");
  endtask : t_tx
  task t_user;
    USER_CTX <= 32'h12345678;
    user(3'b001);
    chk("run", STATE_FLAGS[2:1], 2'b01);
    user(3'b100);
    chk("trap", STATE_FLAGS[2:1], 2'b10);
    chk("saved", SAVED_CTX, 32'h12345678);
    user(3'b001);
    chk("restart", STATE_FLAGS[2:1], 2'b01);
    user(3'b010);
    chk("stop", STATE_FLAGS[2:1], 2'b00);
    DIAG_MODE <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk("diag", STATE_FLAGS[FLAG_DIAG], 1'b1);
    $display("t_user done");
  endtask : t_user
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    chk("reset", {STATE_FLAGS, MEM_POINTER}, {FLAGS_RESET, ADDR_RESET});
    t_data;
    t_tx;
    t_user;
    tally_and_finish;
  end
  initial begin
    repeat (1000) @(posedge CLOCK);
    num_errors++;
    tally_and_finish;
  end
endmodule : tb_serial_monitor_command_core
`default_nettype wire
